// [rtl/tmr_capture_timer.sv]
// 16-bit up-counter with two capture/compare registers, AXI4-Lite registers
// Assumes timer pins are asynchronous; they are synchronised inside
//
// How it works
// - Edge-clear mode counts up; first input valid edge clears counter, else it wraps.
// - Inputs sampled on the sampling enable; edge valid after two equal samples.
// - Both capture: second input edge, or reverse first-input phase, captures first.
// - Both capture: first input valid edge captures into second register, second event.
// - In edge-clear mode the counter clears on the same clock edge as the capture, which keeps the count from before the clear.
// - Invert bit 0 toggles output on match only; 1 also on first input edge.
// - Reverse-phase bit set: opposite first-input edge captures first register, no event.
// - Reverse-phase bit set: second input edge raises first event, no capture.
// - Edge fields decode 00 falling, 01 rising, 11 both, 10 none.
// - Second input edge field sits at prescaler bits 6 and 5, triggers first capture.
// - First register as compare raises first event on equality, no clear.
// - Second register as compare raises second event on equality, no clear.
// - First register as capture takes first or second input as trigger.
// - Second register as capture always triggers on the first input.
// - Output pin unavailable while second input edge detection is in use.
// - Mode 01 runs free, counting up on every count clock.
// - After FFFF the next count clock sets overflow and wraps to zero.
// - Free run supports compare/compare, compare/capture and capture/capture.
//
// Design decisions made here: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps
`include "tmr_defs.svh"
module tmr_capture_timer (
    input wire logic i_clk_sys, // 40 MHz system clock
    input wire logic i_rst, // Async reset, active high
    input wire logic i_awvalid, // Write address valid
    output logic o_awready, // Write address ready
    input wire logic [7:0] i_awaddr, // Write byte address
    input wire logic i_wvalid, // Write data valid
    output logic o_wready, // Write data ready
    input wire logic [31:0] i_wdata, // Write data
    input wire logic [3:0] i_wstrb, // Write byte strobes
    output logic o_bvalid, // Write response valid
    input wire logic i_bready, // Write response ready
    output logic [1:0] o_bresp, // Write response
    input wire logic i_arvalid, // Read address valid
    output logic o_arready, // Read address ready
    input wire logic [7:0] i_araddr, // Read byte address
    output logic o_rvalid, // Read data valid
    input wire logic i_rready, // Read data ready
    output logic [31:0] o_rdata, // Read data
    output logic [1:0] o_rresp, // Read response
    input wire logic i_first_timer_input, // First timer input pin
    input wire logic i_second_timer_input, // Second timer input pin
    output logic o_timer_output_pin, // Timer output level
    output logic o_timer_output_en, // Timer output drive enable
    output logic o_first_channel_event, // First channel event pulse
    output logic o_second_channel_event // Second channel event pulse
);
    import tmr_pkg::*;

    tmr_core_s s_r;
    tmr_core_s s_nxt;
    tmr_wr_s wr;
    tmr_edge_s [1:0] pin_edge;
    tmr_mode_e mode;
    logic [1:0] pin_in;
    logic [7:0] rd_addr;
    logic [31:0] rd_data;
    logic rd_err;
    logic wr_err;
    logic run;
    logic smp_en;
    logic cnt_tick;
    logic ti0_v;
    logic ti1_v;
    logic ti0_rev;
    logic cc0_cap;
    logic cc1_cap;
    logic rev_sel;
    logic cmp0;
    logic cmp1;
    logic ti1_used;
    logic tog;

    function automatic logic edge_ok(input logic [1:0] es, input tmr_edge_s e);
        logic ok;
        ok = 1'b0;
        unique case (es)
            2'b00: ok = e.fall;
            2'b01: ok = e.rise;
            2'b11: ok = e.rise | e.fall;
            default: ok = 1'b0;
        endcase
        return ok;
    endfunction : edge_ok

    // Field that selects the edge opposite to the chosen one
    function automatic logic [1:0] opp_es(input logic [1:0] es);
        logic [1:0] o;
        o = 2'b10;
        if (es == 2'b00) begin
            o = 2'b01;
        end else if (es == 2'b01) begin
            o = 2'b00;
        end
        return o;
    endfunction : opp_es

    function automatic logic [15:0] merge16(input logic [15:0] old,
                                            input logic [31:0] d,
                                            input logic [3:0] st);
        logic [15:0] m;
        m = old;
        if (st[0]) begin
            m[7:0] = d[7:0];
        end
        if (st[1]) begin
            m[15:8] = d[15:8];
        end
        return m;
    endfunction : merge16

    function automatic logic mapped(input logic [7:0] a);
        return a inside {`TMR_OFS_PRESCALER, `TMR_OFS_COUNTER, `TMR_OFS_CC_FIRST,
                         `TMR_OFS_CC_SECOND, `TMR_OFS_MODE_CTL, `TMR_OFS_CC_CTL,
                         `TMR_OFS_OUT_CTL, `TMR_OFS_STATUS};
    endfunction : mapped

    tmr_axil u_axil (
        .i_clk_sys(i_clk_sys),
        .i_rst(i_rst),
        .i_awvalid(i_awvalid),
        .o_awready(o_awready),
        .i_awaddr(i_awaddr),
        .i_wvalid(i_wvalid),
        .o_wready(o_wready),
        .i_wdata(i_wdata),
        .i_wstrb(i_wstrb),
        .o_bvalid(o_bvalid),
        .i_bready(i_bready),
        .o_bresp(o_bresp),
        .i_arvalid(i_arvalid),
        .o_arready(o_arready),
        .i_araddr(i_araddr),
        .o_rvalid(o_rvalid),
        .i_rready(i_rready),
        .o_rdata(o_rdata),
        .o_rresp(o_rresp),
        .o_wr(wr),
        .o_rd_addr(rd_addr),
        .i_rdata(rd_data),
        .i_rd_err(rd_err),
        .i_wr_err(wr_err)
    );

    assign pin_in = {i_second_timer_input, i_first_timer_input};
    assign smp_en = (s_r.div & `TMR_SMP_MSK) == `TMR_SMP_MSK;

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_pin
            tmr_edge_flt u_flt (
                .i_clk_sys(i_clk_sys),
                .i_rst(i_rst),
                .i_pin(pin_in[gi]),
                .i_smp_en(smp_en),
                .o_edge(pin_edge[gi])
            );
        end
    endgenerate

    // Mode and arrangement decode
    assign mode = tmr_mode_e'(s_r.tmc[`TMR_MODE_LSB +: 2]);
    assign run = (mode == TMR_MODE_FREE) || (mode == TMR_MODE_EDGE_CLR);
    assign cc0_cap = s_r.crc[`TMR_CC0_CAP_BIT];
    assign cc1_cap = s_r.crc[`TMR_CC1_CAP_BIT];
    assign rev_sel = s_r.crc[`TMR_REV_BIT];
    assign ti0_v = edge_ok(s_r.prm[`TMR_ES0_LSB +: 2], pin_edge[0]);
    assign ti1_v = edge_ok(s_r.prm[`TMR_ES1_LSB +: 2], pin_edge[1]);
    assign ti0_rev = edge_ok(opp_es(s_r.prm[`TMR_ES0_LSB +: 2]), pin_edge[0]);
    assign ti1_used = cc0_cap;

    // Count clock select; the first input edge as count clock is a software hazard
    always_comb begin
        unique case (s_r.prm[`TMR_CKS_LSB +: 2])
            2'b00: cnt_tick = (s_r.div & `TMR_CK0_MSK) == `TMR_CK0_MSK;
            2'b01: cnt_tick = (s_r.div & `TMR_CK1_MSK) == `TMR_CK1_MSK;
            2'b10: cnt_tick = (s_r.div & `TMR_CK2_MSK) == `TMR_CK2_MSK;
            2'b11: cnt_tick = ti0_v;
        endcase
    end

    assign cmp0 = run && !cc0_cap && cnt_tick && (s_r.cnt == s_r.cr0);
    assign cmp1 = run && !cc1_cap && cnt_tick && (s_r.cnt == s_r.cr1);
    assign tog = cmp0 || cmp1 || (run && s_r.tmc[`TMR_INV_BIT] && ti0_v);

    always_comb begin
        s_nxt = s_r;
        s_nxt.ev0 = 1'b0;
        s_nxt.ev1 = 1'b0;
        s_nxt.div = s_r.div + `TMR_DIV_W'(1);
        // Software writes first so that hardware events win in the same cycle
        if (wr.en) begin
            unique case (wr.addr)
                `TMR_OFS_PRESCALER: begin
                    if (wr.strb[0]) begin
                        s_nxt.prm = wr.data[7:0];
                    end
                end
                `TMR_OFS_CC_FIRST: s_nxt.cr0 = merge16(s_r.cr0, wr.data, wr.strb);
                `TMR_OFS_CC_SECOND: s_nxt.cr1 = merge16(s_r.cr1, wr.data, wr.strb);
                `TMR_OFS_MODE_CTL: begin
                    if (wr.strb[0]) begin
                        s_nxt.tmc = wr.data[3:0];
                    end
                end
                `TMR_OFS_CC_CTL: begin
                    if (wr.strb[0]) begin
                        s_nxt.crc = wr.data[2:0];
                    end
                end
                `TMR_OFS_OUT_CTL: begin
                    if (wr.strb[0]) begin
                        s_nxt.toc = wr.data[`TMR_OE_BIT];
                    end
                end
                `TMR_OFS_STATUS: begin
                    if (wr.strb[0] && !wr.data[`TMR_OVF_BIT]) begin
                        s_nxt.ovf = 1'b0;
                    end
                end
                default: s_nxt.ovf = s_nxt.ovf;
            endcase
        end
        if (!run) begin
            s_nxt.cnt = `TMR_RST_16;
        end else begin
            if (cnt_tick) begin
                s_nxt.cnt = s_r.cnt + 16'h0001;
                if (s_r.cnt == `TMR_CNT_MAX) begin
                    s_nxt.ovf = 1'b1;
                end
            end
            if (mode == TMR_MODE_EDGE_CLR && ti0_v) begin
                s_nxt.cnt = `TMR_RST_16;
            end
            // Captures take the count held before any clear of this cycle
            if (cc0_cap) begin
                if (!rev_sel && ti1_v) begin
                    s_nxt.cr0 = s_r.cnt;
                    s_nxt.ev0 = 1'b1;
                end
                if (rev_sel && ti0_rev) begin
                    s_nxt.cr0 = s_r.cnt;
                end
                if (rev_sel && ti1_v) begin
                    s_nxt.ev0 = 1'b1;
                end
            end
            if (cc1_cap && ti0_v) begin
                s_nxt.cr1 = s_r.cnt;
                s_nxt.ev1 = 1'b1;
            end
            if (cmp0) begin
                s_nxt.ev0 = 1'b1;
            end
            if (cmp1) begin
                s_nxt.ev1 = 1'b1;
            end
            if (tog) begin
                s_nxt.to = ~s_r.to;
            end
        end
    end

    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    // Register read view
    assign rd_err = !mapped(rd_addr);
    assign wr_err = !mapped(wr.addr);

    always_comb begin
        rd_data = 32'h0000_0000;
        unique case (rd_addr)
            `TMR_OFS_PRESCALER: rd_data[7:0] = s_r.prm;
            `TMR_OFS_COUNTER: rd_data[15:0] = s_r.cnt;
            `TMR_OFS_CC_FIRST: rd_data[15:0] = s_r.cr0;
            `TMR_OFS_CC_SECOND: rd_data[15:0] = s_r.cr1;
            `TMR_OFS_MODE_CTL: rd_data[3:0] = s_r.tmc;
            `TMR_OFS_CC_CTL: rd_data[2:0] = s_r.crc;
            `TMR_OFS_OUT_CTL: rd_data[`TMR_OE_BIT] = s_r.toc;
            `TMR_OFS_STATUS: rd_data[`TMR_OVF_BIT] = s_r.ovf;
            default: rd_data = 32'h0000_0000;
        endcase
    end

    assign o_timer_output_pin = s_r.to && !ti1_used;
    assign o_timer_output_en = s_r.toc && !ti1_used;
    assign o_first_channel_event = s_r.ev0;
    assign o_second_channel_event = s_r.ev1;

    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (i_rst);

    sequence s_clr_edge;
        run && mode == TMR_MODE_EDGE_CLR && ti0_v;
    endsequence

    sequence s_cnt_zero;
        s_r.cnt == `TMR_RST_16;
    endsequence

    a_edge_clears_cnt:
        assert property (s_clr_edge |=> s_cnt_zero)
        else $error("counter not cleared after first input edge");

    a_cap_second_reg:
        assert property (run && cc1_cap && ti0_v |=> s_r.cr1 == $past(s_r.cnt) && s_r.ev1)
        else $error("second register capture or event missing");

    a_cap_first_reg:
        assert property (run && cc0_cap && !rev_sel && ti1_v
                         |=> s_r.cr0 == $past(s_r.cnt) && o_first_channel_event)
        else $error("first register capture on second input failed");

    a_rev_no_event:
        assert property (run && cc0_cap && rev_sel && ti0_rev && !ti1_v
                         |=> s_r.cr0 == $past(s_r.cnt) && !o_first_channel_event)
        else $error("reverse phase capture wrong");

    a_rev_evt_only:
        assert property (run && cc0_cap && rev_sel && ti1_v && !ti0_rev && !wr.en
                         |=> o_first_channel_event && $stable(s_r.cr0))
        else $error("second input edge captured under reverse phase");

    a_ovf_wraps:
        assert property (run && cnt_tick && s_r.cnt == `TMR_CNT_MAX
                         |=> s_r.ovf and s_cnt_zero)
        else $error("overflow did not set and wrap");

    a_ovf_sticky:
        assert property (s_r.ovf && !(wr.en && wr.addr == `TMR_OFS_STATUS) |=> s_r.ovf)
        else $error("overflow flag cleared without a write");

    a_free_count:
        assert property (mode == TMR_MODE_FREE && cnt_tick && s_r.cnt != `TMR_CNT_MAX
                         |=> s_r.cnt == $past(s_r.cnt) + 16'h0001)
        else $error("free run did not count up");

    a_cmp_first:
        assert property (cmp0 |=> o_first_channel_event ##1 !o_first_channel_event)
        else $error("first compare event not a single pulse");

    a_cmp_second_nc:
        assert property (cmp1 && mode == TMR_MODE_FREE && s_r.cnt != `TMR_CNT_MAX
                         |=> o_second_channel_event && s_r.cnt != `TMR_RST_16)
        else $error("second compare event wrong or counter cleared");

    a_out_toggle:
        assert property (tog |=> s_r.to != $past(s_r.to))
        else $error("output did not toggle");

    a_out_hold:
        assert property (run && !tog |=> $stable(s_r.to))
        else $error("output toggled without cause");

    a_out_gated:
        assert property (ti1_used |-> !o_timer_output_en && !o_timer_output_pin)
        else $error("output driven while second input in use");

    a_stop_clear:
        assert property (!run |=> s_cnt_zero and !o_second_channel_event)
        else $error("stopped counter not held at zero");

endmodule : tmr_capture_timer

// [rtl/tmr_defs.svh]
// Register offsets, field positions, reset values and divider masks of the timer
// Definitions only; included by each timer module file, not by the type package
`ifndef TMR_DEFS_SVH
`define TMR_DEFS_SVH

`define TMR_OFS_PRESCALER 8'h00
`define TMR_OFS_COUNTER 8'h04
`define TMR_OFS_CC_FIRST 8'h08
`define TMR_OFS_CC_SECOND 8'h0C
`define TMR_OFS_MODE_CTL 8'h10
`define TMR_OFS_CC_CTL 8'h14
`define TMR_OFS_OUT_CTL 8'h18
`define TMR_OFS_STATUS 8'h1C

`define TMR_CKS_LSB 0
`define TMR_ES0_LSB 2
`define TMR_ES1_LSB 5
`define TMR_MODE_LSB 2
`define TMR_INV_BIT 1
`define TMR_CC0_CAP_BIT 0
`define TMR_REV_BIT 1
`define TMR_CC1_CAP_BIT 2
`define TMR_OE_BIT 0
`define TMR_OVF_BIT 0

`define TMR_RST_16 16'h0000
`define TMR_RST_8 8'h00
`define TMR_CNT_MAX 16'hFFFF

`define TMR_DIV_W 6
`define TMR_SMP_MSK 6'h01
`define TMR_CK0_MSK 6'h01
`define TMR_CK1_MSK 6'h03
`define TMR_CK2_MSK 6'h3F

`define TMR_RESP_OKAY 2'b00
`define TMR_RESP_SLVERR 2'b10

`endif

// [rtl/tmr_pkg.sv]
// Types shared by the capture/compare timer files
// Field widths follow the register layout in tmr_defs.svh
package tmr_pkg;

    typedef enum logic [1:0] {
        TMR_MODE_STOP = 2'b00,
        TMR_MODE_FREE = 2'b01,
        TMR_MODE_EDGE_CLR = 2'b10,
        TMR_MODE_MATCH_CLR = 2'b11
    } tmr_mode_e;

    typedef struct packed {
        logic rise;
        logic fall;
    } tmr_edge_s;

    typedef struct packed {
        logic en;
        logic [7:0] addr;
        logic [31:0] data;
        logic [3:0] strb;
    } tmr_wr_s;

    typedef struct packed {
        logic [1:0] sync;
        logic smp;
        logic lvl;
        tmr_edge_s ev;
    } tmr_flt_s;

    typedef struct packed {
        logic aw_full;
        logic [7:0] awaddr;
        logic w_full;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } tmr_axi_s;

    typedef struct packed {
        logic [7:0] prm;
        logic [3:0] tmc;
        logic [2:0] crc;
        logic toc;
        logic [15:0] cnt;
        logic [15:0] cr0;
        logic [15:0] cr1;
        logic ovf;
        logic to;
        logic ev0;
        logic ev1;
        logic [5:0] div;
    } tmr_core_s;

endpackage : tmr_pkg

// [rtl/tmr_edge_flt.sv]
// Pin synchroniser and two-sample edge filter for one timer input
// Assumes i_smp_en is a one-cycle pulse of the sampling rate on i_clk_sys
`timescale 1ns/1ps
`include "tmr_defs.svh"
module tmr_edge_flt (
    input wire logic i_clk_sys, // System clock
    input wire logic i_rst, // Async reset, active high
    input wire logic i_pin, // Raw timer input pin
    input wire logic i_smp_en, // Sampling-clock enable pulse
    output tmr_pkg::tmr_edge_s o_edge // Filtered edge pulses
);
    import tmr_pkg::*;

    tmr_flt_s s_r;
    tmr_flt_s s_nxt;

    always_comb begin
        s_nxt = s_r;
        s_nxt.sync = {s_r.sync[0], i_pin};
        s_nxt.ev = '0;
        if (i_smp_en) begin
            s_nxt.smp = s_r.sync[1];
            // Level accepted only when two samples in a row agree
            if (s_r.sync[1] == s_r.smp && s_r.sync[1] != s_r.lvl) begin
                s_nxt.lvl = s_r.sync[1];
                s_nxt.ev.rise = s_r.sync[1];
                s_nxt.ev.fall = ~s_r.sync[1];
            end
        end
    end

    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign o_edge = s_r.ev;

endmodule : tmr_edge_flt

// [rtl/tmr_axil.sv]
// AXI4-Lite slave front end: one write and one read outstanding
// Assumes the core decodes o_wr and o_rd_addr combinationally in the same cycle
`timescale 1ns/1ps
`include "tmr_defs.svh"
module tmr_axil (
    input wire logic i_clk_sys, // System clock
    input wire logic i_rst, // Async reset, active high
    input wire logic i_awvalid, // Write address valid
    output logic o_awready, // Write address ready
    input wire logic [7:0] i_awaddr, // Write byte address
    input wire logic i_wvalid, // Write data valid
    output logic o_wready, // Write data ready
    input wire logic [31:0] i_wdata, // Write data
    input wire logic [3:0] i_wstrb, // Write byte strobes
    output logic o_bvalid, // Write response valid
    input wire logic i_bready, // Write response ready
    output logic [1:0] o_bresp, // Write response
    input wire logic i_arvalid, // Read address valid
    output logic o_arready, // Read address ready
    input wire logic [7:0] i_araddr, // Read byte address
    output logic o_rvalid, // Read data valid
    input wire logic i_rready, // Read data ready
    output logic [31:0] o_rdata, // Read data
    output logic [1:0] o_rresp, // Read response
    output tmr_pkg::tmr_wr_s o_wr, // Register write strobe
    output logic [7:0] o_rd_addr, // Register read address
    input wire logic [31:0] i_rdata, // Register read data
    input wire logic i_rd_err, // Read address unmapped
    input wire logic i_wr_err // Write address unmapped
);
    import tmr_pkg::*;

    tmr_axi_s s_r;
    tmr_axi_s s_nxt;
    logic wr_fire;

    assign wr_fire = s_r.aw_full && s_r.w_full && !s_r.bvalid;
    assign o_awready = !s_r.aw_full;
    assign o_wready = !s_r.w_full;
    assign o_arready = !s_r.rvalid;
    assign o_rd_addr = i_araddr;
    assign o_wr = '{en: wr_fire, addr: s_r.awaddr, data: s_r.wdata, strb: s_r.wstrb};

    always_comb begin
        s_nxt = s_r;
        if (s_r.bvalid && i_bready) begin
            s_nxt.bvalid = 1'b0;
        end
        if (i_awvalid && !s_r.aw_full) begin
            s_nxt.aw_full = 1'b1;
            s_nxt.awaddr = i_awaddr;
        end
        if (i_wvalid && !s_r.w_full) begin
            s_nxt.w_full = 1'b1;
            s_nxt.wdata = i_wdata;
            s_nxt.wstrb = i_wstrb;
        end
        if (wr_fire) begin
            s_nxt.aw_full = 1'b0;
            s_nxt.w_full = 1'b0;
            s_nxt.bvalid = 1'b1;
            s_nxt.bresp = i_wr_err ? `TMR_RESP_SLVERR : `TMR_RESP_OKAY;
        end
        if (s_r.rvalid && i_rready) begin
            s_nxt.rvalid = 1'b0;
        end
        if (i_arvalid && !s_r.rvalid) begin
            s_nxt.rvalid = 1'b1;
            s_nxt.rdata = i_rdata;
            s_nxt.rresp = i_rd_err ? `TMR_RESP_SLVERR : `TMR_RESP_OKAY;
        end
    end

    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign o_bvalid = s_r.bvalid;
    assign o_bresp = s_r.bresp;
    assign o_rvalid = s_r.rvalid;
    assign o_rdata = s_r.rdata;
    assign o_rresp = s_r.rresp;

endmodule : tmr_axil

// [test/tmr_pin_model.sv]
// Far side of the timer pins: drives both input levels
// Assumes the bench calls drive between its register accesses
`timescale 1ns/1ps
module tmr_pin_model (
    input wire logic i_clk_sys, // System clock
    output logic o_first, // First timer input level
    output logic o_second // Second timer input level
);
    initial begin
        o_first = 1'b0;
        o_second = 1'b0;
    end
    // Levels held 8 clocks so two samples agree
    task automatic drive(input logic f, input logic s);
        @(posedge i_clk_sys);
        o_first <= f;
        o_second <= s;
        repeat (8) @(posedge i_clk_sys);
    endtask : drive
endmodule : tmr_pin_model

// [test/tmr_capture_timer_tb.sv]
// Self-checking bench: register model over AXI4-Lite plus pin scenarios
// Assumes the pin model is compiled first
`timescale 1ns/1ps
module tmr_capture_timer_tb;
    logic clk = 1'b0, rst = 1'b1, awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
    logic [7:0] awa = 8'h00, ara = 8'h00;
    logic [31:0] wd = 32'h0000_0000, rdat;
    logic awr, wrd, bv, arr, rv, tp, toe, f1, f2, e1, e2;
    logic [1:0] br, rr, resp;
    logic [31:0] rd;
    logic [7:0] ofs[5] = '{8'h00, 8'h08, 8'h0c, 8'h14, 8'h18};
    int unsigned msk[5] = '{32'h0000_00ff, 32'h0000_ffff, 32'h0000_ffff, 32'h0000_0007, 32'h0000_0001};
    int bad_count = 0, compares = 0, n1 = 0, n2 = 0, b, seed = 32'h0eb0_708d;
    int unsigned v;
    logic o;
    always #12.5 clk = ~clk;
    always @(posedge clk) begin
        n1 <= n1 + int'(e1);
        n2 <= n2 + int'(e2);
    end
    tmr_capture_timer tmr_capture_timer_inst (.i_clk_sys(clk), .i_rst(rst), .i_awvalid(awv),
        .o_awready(awr), .i_awaddr(awa), .i_wvalid(wv), .o_wready(wrd), .i_wdata(wd),
        .i_wstrb(4'hf), .o_bvalid(bv), .i_bready(bry), .o_bresp(br), .i_arvalid(arv),
        .o_arready(arr), .i_araddr(ara), .o_rvalid(rv), .i_rready(rry), .o_rdata(rd),
        .o_rresp(rr), .i_first_timer_input(f1), .i_second_timer_input(f2),
        .o_timer_output_pin(tp), .o_timer_output_en(toe), .o_first_channel_event(e1),
        .o_second_channel_event(e2));
    tmr_pin_model tmr_pin_model_inst (.i_clk_sys(clk), .o_first(f1), .o_second(f2));
    task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
        logic pa, pw, ta, tw, g;
        pa = 1'b1;
        pw = 1'b1;
        @(posedge clk);
        awv <= 1'b1;
        awa <= a;
        wv <= 1'b1;
        wd <= d;
        bry <= 1'b1;
        while (pa | pw) begin
            @(negedge clk);
            ta = pa & awr;
            tw = pw & wrd;
            @(posedge clk);
            if (ta) awv <= 1'b0;
            if (tw) wv <= 1'b0;
            pa = pa & ~ta;
            pw = pw & ~tw;
        end
        do begin
            @(negedge clk);
            g = bv;
            resp = br;
            @(posedge clk);
        end while (g !== 1'b1);
        bry <= 1'b0;
    endtask : bus_wr
    task automatic bus_rd(input logic [7:0] a);
        logic g;
        @(posedge clk);
        arv <= 1'b1;
        ara <= a;
        rry <= 1'b1;
        do begin
            @(negedge clk);
            g = arr;
            @(posedge clk);
        end while (g !== 1'b1);
        arv <= 1'b0;
        do begin
            @(negedge clk);
            g = rv;
            rdat = rd;
            resp = rr;
            @(posedge clk);
        end while (g !== 1'b1);
        rry <= 1'b0;
    endtask : bus_rd
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        compares++;
        if (s !== e) begin
            bad_count++;
            $display("unexpected %s: expected %h seen %h", nm, e, s);
        end
    endtask : chk
    task automatic tally_and_finish();
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : tally_and_finish
    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        tally_and_finish();
    end
    initial begin
        v = $random(seed);
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        bus_wr(8'h1c, 32'h0000_0000);
        for (int i = 0; i < 8; i++) begin
            bus_rd(8'(i * 4));
            chk("reset", 0, rdat);
        end
        for (int i = 0; i < 5; i++) begin
            v = $random(seed);
            bus_wr(ofs[i], v);
            bus_rd(ofs[i]);
            chk("reg", v & msk[i], rdat);
            bus_wr(ofs[i], 0);
        end
        bus_wr(8'h20, 1);
        chk("bresp", 2, 32'(resp));
        bus_rd(8'h20);
        chk("rresp", 2, 32'(resp));
        $display("test registers done");
        bus_wr(8'h08, 32'h0000_0010);
        bus_wr(8'h0c, 32'h0000_0020);
        bus_wr(8'h10, 32'h0000_0004);
        repeat (150) @(posedge clk);
        bus_rd(8'h04);
        v = rdat;
        bus_rd(8'h04);
        chk("count up", 1, 32'(rdat > v && v > 32));
        chk("match one", 1, n1);
        chk("match two", 1, n2);
        $display("test free run done");
        bus_wr(8'h08, 32'h0000_ffff);
        bus_wr(8'h14, 32'h0000_0004);
        bus_wr(8'h00, 32'h0000_0004);
        bus_wr(8'h18, 32'h0000_0001);
        bus_wr(8'h10, 32'h0000_000a);
        repeat (100) @(posedge clk);
        o = tp;
        b = n2;
        tmr_pin_model_inst.drive(1'b1, 1'b0);
        bus_rd(8'h0c);
        v = rdat;
        bus_rd(8'h04);
        chk("capture two", 1, 32'(v > 40 && rdat < v));
        chk("event two", b + 1, n2);
        chk("out toggle", {31'h0, ~o}, {31'h0, tp});
        chk("out enable", 1, {31'h0, toe});
        bus_wr(8'h14, 32'h0000_0005);
        bus_wr(8'h00, 32'h0000_0024);
        b = n1;
        tmr_pin_model_inst.drive(1'b1, 1'b1);
        bus_rd(8'h08);
        chk("capture one", 1, 32'(rdat > 0 && rdat < 32'h0000_ffff));
        chk("event one", b + 1, n1);
        chk("out gated", 0, {30'h0, toe, tp});
        bus_wr(8'h14, 32'h0000_0007);
        bus_rd(8'h08);
        v = rdat;
        b = n1;
        tmr_pin_model_inst.drive(1'b0, 1'b0);
        bus_rd(8'h08);
        chk("rev capture", 1, 32'(rdat > v));
        chk("rev no event", b, n1);
        v = rdat;
        tmr_pin_model_inst.drive(1'b0, 1'b1);
        bus_rd(8'h08);
        chk("rev hold", v, rdat);
        chk("rev event", b + 1, n1);
        $display("test edge clear done");
        tally_and_finish();
    end
endmodule : tmr_capture_timer_tb
